// *** rtl/rxpbc_pkg.sv ***
// Constants, register map and types of the receive polling sequencer.
// Assumes a 125 MHz system clock and an APB slave with 32-bit data.
package rxpbc_pkg;
    localparam logic [7:0] RXPBC_OFS_MODE = 8'h00;
    localparam logic [7:0] RXPBC_OFS_SLEEP = 8'h04;
    localparam logic [7:0] RXPBC_OFS_LIMMIN = 8'h08;
    localparam logic [7:0] RXPBC_OFS_LIMMAX = 8'h0c;
    localparam logic [7:0] RXPBC_OFS_STATUS = 8'h10;
    localparam logic [7:0] RXPBC_OFS_CLKDIV = 8'h14;

    localparam int RXPBC_SLEEP_POS = 0;
    localparam int RXPBC_XSLEEP_POS = 5;
    localparam int RXPBC_LIM_POS = 0;
    localparam int RXPBC_NBIT_POS = 6;
    localparam int RXPBC_OPM_POS = 0;
    localparam int RXPBC_TSEL_POS = 2;
    localparam int RXPBC_PSEL_POS = 3;
    localparam int RXPBC_ACK_POS = 4;

    localparam logic [1:0] RXPBC_OPM_POLL = 2'h2;
    localparam logic [1:0] RXPBC_OPM_RX = 2'h3;
    localparam logic [10:0] RXPBC_SLEEP_UNIT = 11'h400;
    localparam logic [3:0] RXPBC_XSLEEP_ONE = 4'h1;
    localparam logic [3:0] RXPBC_XSLEEP_EIGHT = 4'h8;
    localparam logic [4:0] RXPBC_CHECKS_PER_BIT3 = 5'h06;

    localparam logic [4:0] RXPBC_MODE_RST = 5'h00;
    localparam logic [5:0] RXPBC_SLEEP_RST = 6'h00;
    localparam logic [7:0] RXPBC_LIMMIN_RST = 8'h0e;
    localparam logic [5:0] RXPBC_LIMMAX_RST = 6'h18;
    localparam logic [15:0] RXPBC_DDIV_RST = 16'h000f;
    localparam logic [15:0] RXPBC_XDIV_RST = 16'h000f;

    typedef enum logic [4:0] {
        RXPBC_ST_IDLE = 5'h01,
        RXPBC_ST_SLEEP = 5'h02,
        RXPBC_ST_PLL = 5'h04,
        RXPBC_ST_SIG = 5'h08,
        RXPBC_ST_CHECK = 5'h10
    } rxpbc_state_type;
endpackage

// *** rtl/rxpbc_tick.sv ***
// Programmable tick divider: one-cycle pulse every div_in+1 clocks.
// Assumes div_in is static while in use; a change takes hold at once, in the running count.
`timescale 1ns/100ps
module rxpbc_tick (
    input wire logic ref_clk_in,
    input wire logic srst_in,
    input wire logic [15:0] div_in,
    output logic tick_out
);
    typedef struct packed {
        logic [15:0] cnt;
        logic tick;
    } rxpbc_tick_type;
    rxpbc_tick_type s_r;
    rxpbc_tick_type s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.tick = 1'b0;
        if (s_r.cnt >= div_in) begin
            s_nxt.cnt = 16'h0000;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.cnt = s_r.cnt + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tick_out = s_r.tick;
endmodule

// *** rtl/rxpbc_top.sv ***
// Receive polling sequencer: sleep, PLL and signal start-up, edge bit check.
// Assumes demod_in, pll_lock_in and APB inputs are synchronous to ref_clk_in.
//
// Summary of operation
// - Polling repeats sleep, start-up, bit check until a check succeeds.
// - Receive path stays disabled through the whole sleep period.
// - A failed bit check returns to sleep when polling, to signal start-up in continuous receive.
// - rx_activity_indicator shows the current polling phase.
// - Sleep lasts sleep count times 1024 basic periods times extension.
// - Extension select gives factor 1 when clear, 8 when set.
// - PLL starts first; signal start-up only after lock.
// - Each edge-to-edge interval is measured against the window.
// - Checked bit count 0,3,6,9 gives 0,6,12,18 interval checks.
// - Inside window continues; too short or too long aborts to sleep when polling, to signal start-up in continuous receive.
// - After all checks pass the block enters receiving mode.
// - Lower window is lower limit periods; upper is upper limit periods.
// - Lower limit is 6 bits in register 5, upper in register 6.
// - Interval counter advances once per check clock period.
// - Edge below lower limit fails; reaching upper limit without edge fails.
// - Demodulator output is ignored during both start-up phases.
// - Receiving sets supply and clock enables; interrupt only if both selects clear.
// - Mode code 10 selects polling, 11 continuous receive.
// - Continuous receive keeps radio on and checks without sleep.
`timescale 1ns/100ps
module rxpbc_top
    import rxpbc_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic srst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic demod_in,
    input wire logic pll_lock_in,
    output logic rx_enable_out,
    output logic pll_enable_out,
    output logic sig_proc_enable_out,
    output logic rx_activity_indicator_out,
    output logic receiving_out,
    output logic supply_output_enable_out,
    output logic clock_output_enable_out,
    output logic irq_out
);
    import rxpbc_pkg::*;

    typedef struct packed {
        logic [4:0] mode;
        logic [5:0] sleep_cfg;
        logic [7:0] limmin;
        logic [5:0] limmax;
        logic [15:0] ddiv;
        logic [15:0] xdiv;
        rxpbc_state_type st;
        logic [18:0] sleep_cnt;
        logic [5:0] eic;
        logic [4:0] checks;
        logic demod_d;
        logic receiving;
        logic supply_en;
        logic clk_en;
        logic irq;
        logic [31:0] prdata;
    } rxpbc_top_type;

    rxpbc_top_type s_r;
    rxpbc_top_type s_nxt;
    logic dtick;
    logic xtick;
    logic acc;
    logic wr;
    logic mapped;
    logic polling;
    logic rx_cont;
    logic edge_seen;
    logic [4:0] checks_target;
    logic [3:0] xfac;
    logic [18:0] sleep_target;
    logic [31:0] status_word;
    logic rx_done;

    rxpbc_tick u_dclk (
        .ref_clk_in(ref_clk_in),
        .srst_in(srst_in),
        .div_in(s_r.ddiv),
        .tick_out(dtick)
    );

    rxpbc_tick u_xclk (
        .ref_clk_in(ref_clk_in),
        .srst_in(srst_in),
        .div_in(s_r.xdiv),
        .tick_out(xtick)
    );

    assign acc = psel_in && penable_in;
    assign wr = acc && pwrite_in;
    assign mapped = (paddr_in == RXPBC_OFS_MODE) || (paddr_in == RXPBC_OFS_SLEEP) ||
                    (paddr_in == RXPBC_OFS_LIMMIN) || (paddr_in == RXPBC_OFS_LIMMAX) ||
                    (paddr_in == RXPBC_OFS_STATUS) || (paddr_in == RXPBC_OFS_CLKDIV);
    assign polling = (s_r.mode[1:0] == RXPBC_OPM_POLL);
    assign rx_cont = (s_r.mode[1:0] == RXPBC_OPM_RX);
    assign edge_seen = demod_in ^ s_r.demod_d;
    // Three bits per step, two interval checks per bit
    assign checks_target = 5'(s_r.limmin[7:RXPBC_NBIT_POS] * RXPBC_CHECKS_PER_BIT3);
    assign xfac = s_r.sleep_cfg[RXPBC_XSLEEP_POS] ? RXPBC_XSLEEP_EIGHT : RXPBC_XSLEEP_ONE;
    assign sleep_target = 19'(s_r.sleep_cfg[4:0] * RXPBC_SLEEP_UNIT * xfac);
    assign status_word = {19'h00000, s_r.irq, s_r.receiving, s_r.st, s_r.eic};
    assign rx_done = (s_r.st == RXPBC_ST_CHECK) && (s_r.checks >= checks_target);

    always_comb begin
        s_nxt = s_r;
        s_nxt.demod_d = demod_in;
        s_nxt.prdata = 32'h00000000;
        // Loaded in the setup cycle so the word stands while pready is high
        if (psel_in && !penable_in && !pwrite_in) begin
            unique case (paddr_in)
                RXPBC_OFS_MODE: s_nxt.prdata = {27'h0000000, s_r.mode};
                RXPBC_OFS_SLEEP: s_nxt.prdata = {26'h0000000, s_r.sleep_cfg};
                RXPBC_OFS_LIMMIN: s_nxt.prdata = {24'h000000, s_r.limmin};
                RXPBC_OFS_LIMMAX: s_nxt.prdata = {26'h0000000, s_r.limmax};
                RXPBC_OFS_STATUS: s_nxt.prdata = status_word;
                RXPBC_OFS_CLKDIV: s_nxt.prdata = {s_r.xdiv, s_r.ddiv};
                default: s_nxt.prdata = 32'h00000000;
            endcase
        end

        // Sequencer
        unique case (s_r.st)
            RXPBC_ST_IDLE: begin
                if (polling && !s_r.receiving) begin
                    s_nxt.st = RXPBC_ST_SLEEP;
                    s_nxt.sleep_cnt = 19'h00000;
                end else if (rx_cont && !s_r.receiving) begin
                    s_nxt.st = RXPBC_ST_PLL;
                end
            end
            RXPBC_ST_SLEEP: begin
                // Radio stays off until the full count is seen
                if (s_r.sleep_cnt >= sleep_target) begin
                    s_nxt.st = RXPBC_ST_PLL;
                end else if (dtick) begin
                    s_nxt.sleep_cnt = s_r.sleep_cnt + 19'h00001;
                end
            end
            RXPBC_ST_PLL: begin
                if (pll_lock_in) begin
                    s_nxt.st = RXPBC_ST_SIG;
                end
            end
            RXPBC_ST_SIG: begin
                // Settle until the next check tick; demod is not looked at here
                if (xtick) begin
                    s_nxt.st = RXPBC_ST_CHECK;
                    s_nxt.eic = 6'h00;
                    s_nxt.checks = 5'h00;
                end
            end
            RXPBC_ST_CHECK: begin
                if (s_r.checks >= checks_target) begin
                    s_nxt.st = RXPBC_ST_IDLE;
                    s_nxt.receiving = 1'b1;
                    s_nxt.supply_en = 1'b1;
                    s_nxt.clk_en = 1'b1;
                    s_nxt.irq = s_r.irq ||
                        (!s_r.mode[RXPBC_TSEL_POS] && !s_r.mode[RXPBC_PSEL_POS]);
                end else if (edge_seen) begin
                    if ({2'h0, s_r.eic} < s_r.limmin[5:0]) begin
                        s_nxt.st = rx_cont ? RXPBC_ST_SIG : RXPBC_ST_SLEEP;
                        s_nxt.sleep_cnt = 19'h00000;
                    end else begin
                        s_nxt.eic = 6'h00;
                        s_nxt.checks = s_r.checks + 5'h01;
                    end
                end else if (s_r.eic >= s_r.limmax) begin
                    s_nxt.st = rx_cont ? RXPBC_ST_SIG : RXPBC_ST_SLEEP;
                    s_nxt.sleep_cnt = 19'h00000;
                end else if (xtick) begin
                    s_nxt.eic = s_r.eic + 6'h01;
                end
            end
            default: s_nxt.st = RXPBC_ST_IDLE;
        endcase

        if (!polling && !rx_cont && s_r.st != RXPBC_ST_IDLE) begin
            s_nxt.st = RXPBC_ST_IDLE;
        end

        if (wr) begin
            unique case (paddr_in)
                RXPBC_OFS_MODE: begin
                    s_nxt.mode = pwdata_in[4:0];
                    // Rewriting the mode restarts the sequence
                    s_nxt.receiving = 1'b0;
                    s_nxt.st = RXPBC_ST_IDLE;
                end
                RXPBC_OFS_SLEEP: s_nxt.sleep_cfg = pwdata_in[5:0];
                RXPBC_OFS_LIMMIN: s_nxt.limmin = pwdata_in[7:0];
                RXPBC_OFS_LIMMAX: s_nxt.limmax = pwdata_in[5:0];
                RXPBC_OFS_STATUS: begin
                    // Write one to acknowledge; a new event in the same cycle wins
                    if (pwdata_in[RXPBC_ACK_POS] && !rx_done) begin
                        s_nxt.irq = 1'b0;
                    end
                    if (pwdata_in[RXPBC_ACK_POS + 1] && !rx_done) begin
                        s_nxt.supply_en = 1'b0;
                        s_nxt.clk_en = 1'b0;
                    end
                end
                RXPBC_OFS_CLKDIV: begin
                    s_nxt.ddiv = pwdata_in[15:0];
                    s_nxt.xdiv = pwdata_in[31:16];
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            s_r <= '0;
            s_r.mode <= RXPBC_MODE_RST;
            s_r.sleep_cfg <= RXPBC_SLEEP_RST;
            s_r.limmin <= RXPBC_LIMMIN_RST;
            s_r.limmax <= RXPBC_LIMMAX_RST;
            s_r.ddiv <= RXPBC_DDIV_RST;
            s_r.xdiv <= RXPBC_XDIV_RST;
            s_r.st <= RXPBC_ST_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata_out = s_r.prdata;
    assign pready_out = 1'b1;
    assign pslverr_out = acc && !mapped;
    assign rx_enable_out = (s_r.st == RXPBC_ST_SIG) || (s_r.st == RXPBC_ST_CHECK) ||
                           s_r.receiving;
    assign pll_enable_out = (s_r.st != RXPBC_ST_IDLE && s_r.st != RXPBC_ST_SLEEP) ||
                            s_r.receiving;
    assign sig_proc_enable_out = rx_enable_out;
    assign rx_activity_indicator_out = (s_r.st != RXPBC_ST_IDLE &&
                                        s_r.st != RXPBC_ST_SLEEP) || s_r.receiving;
    assign receiving_out = s_r.receiving;
    assign supply_output_enable_out = s_r.supply_en;
    assign clock_output_enable_out = s_r.clk_en;
    assign irq_out = s_r.irq;
endmodule

// *** verification/rxpbc_monitor.sv ***
// Port checker for the receive polling sequencer.
// Assumes it is bound into rxpbc_top and sees only that module's ports.
`timescale 1ns/100ps
module rxpbc_monitor (
    input wire logic ref_clk_in,
    input wire logic srst_in,
    input wire logic psel_in,
    input wire logic pwrite_in,
    input wire logic pll_lock_in,
    input wire logic rx_enable_out,
    input wire logic pll_enable_out,
    input wire logic sig_proc_enable_out,
    input wire logic rx_activity_indicator_out,
    input wire logic receiving_out,
    input wire logic supply_output_enable_out,
    input wire logic clock_output_enable_out,
    input wire logic irq_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (srst_in);
    property p_asleep;
        !rx_activity_indicator_out |-> !rx_enable_out && !pll_enable_out;
    endproperty
    a_asleep: assert property (p_asleep) else $error("radio on while idle");
    property p_lock_first;
        $rose(sig_proc_enable_out) |-> $past(pll_lock_in) && pll_enable_out;
    endproperty
    a_lock_first: assert property (p_lock_first) else $error("no lock");
    property p_pll_under;
        sig_proc_enable_out |-> pll_enable_out;
    endproperty
    a_pll_under: assert property (p_pll_under) else $error("pll off");
    property p_act;
        pll_enable_out |-> rx_activity_indicator_out;
    endproperty
    a_act: assert property (p_act) else $error("indicator low");
    property p_recv_on;
        receiving_out |-> rx_enable_out && sig_proc_enable_out;
    endproperty
    a_recv_on: assert property (p_recv_on) else $error("path off");
    property p_recv_hold;
        receiving_out && !(psel_in && pwrite_in) |=> receiving_out;
    endproperty
    a_recv_hold: assert property (p_recv_hold) else $error("receive lost");
    property p_enables;
        $rose(receiving_out) |-> ##[0:1] supply_output_enable_out && clock_output_enable_out;
    endproperty
    a_enables: assert property (p_enables) else $error("enables missing");
    property p_irq;
        $rose(irq_out) |-> ##[0:1] receiving_out;
    endproperty
    a_irq: assert property (p_irq) else $error("stray irq");
    c_recv: cover property ($rose(receiving_out));
    c_fail: cover property ($fell(rx_activity_indicator_out));
    c_lock: cover property ($rose(sig_proc_enable_out));
endmodule

bind rxpbc_top rxpbc_monitor rxpbc_monitor_inst (.*);

// *** verification/rxpbc_xmit.sv ***
// Remote transmitter model: square-wave preburst on the demodulator line.
// Assumes run_in is low while the receive path is off; the line then holds.
`timescale 1ns/100ps
module rxpbc_xmit (
    input wire logic ref_clk_in,
    input wire logic run_in,
    input var int half_in,
    output logic demod_out
);
    int cnt_r;
    initial begin
        demod_out = 1'b0;
        cnt_r = 0;
    end
    // Fixed-frequency 50 percent preburst
    always @(posedge ref_clk_in) begin
        if (!run_in) begin
            cnt_r <= 0;
        end else if (cnt_r >= half_in - 1) begin
            cnt_r <= 0;
            demod_out <= !demod_out;
        end else begin
            cnt_r <= cnt_r + 1;
        end
    end
endmodule

// *** verification/rxpbc_top_tb.sv ***
// Self-checking bench for rxpbc_top with a transmitter model and PLL lock.
// Assumes check tick of 4 clocks, basic tick of 1 clock, window 10..20.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_count++; \
    $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module rxpbc_top_tb;
    import rxpbc_pkg::*;
    logic ref_clk_in, srst_in, psel_in, penable_in, pwrite_in, demod_in, pll_lock_in;
    logic [7:0] paddr_in;
    logic [31:0] pwdata_in, prdata_out, last_rd;
    logic pready_out, pslverr_out, rx_enable_out, pll_enable_out, sig_proc_enable_out;
    logic rx_activity_indicator_out, receiving_out, supply_output_enable_out;
    logic clock_output_enable_out, irq_out, last_err, tx_on;
    int err_count, n_tests, half, lock_cnt, n;
    rxpbc_top rxpbc_top_inst (.*);
    rxpbc_xmit rxpbc_xmit_inst (.ref_clk_in(ref_clk_in), .run_in(tx_on && rx_enable_out),
        .half_in(half), .demod_out(demod_in));
    initial begin
        ref_clk_in = 1'b0;
        forever #4 ref_clk_in = !ref_clk_in;
    end
    // Lock arrives 8 clocks after the PLL is enabled
    always @(posedge ref_clk_in) begin
        lock_cnt <= pll_enable_out ? lock_cnt + 1 : 0;
        pll_lock_in <= pll_enable_out && lock_cnt >= 7;
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge ref_clk_in);
        penable_in <= 1'b1;
        do @(posedge ref_clk_in); while (pready_out !== 1'b1);
        last_err = pslverr_out;
        last_rd = prdata_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    task automatic wait_sig(ref logic s, input logic v, input int lim);
        n = 0;
        while (s !== v && n < lim) begin
            @(posedge ref_clk_in);
            n++;
        end
    endtask
    task automatic cfg(input logic [7:0] slp, lmn, md, input logic tx, input int h);
        tx_on <= tx;
        half <= h;
        apb(1'b1, RXPBC_OFS_SLEEP, {24'h0, slp});
        apb(1'b1, RXPBC_OFS_LIMMIN, {24'h0, lmn});
        apb(1'b1, RXPBC_OFS_MODE, {24'h0, md});
        // Let the restart show on the outputs before any wait starts
        @(posedge ref_clk_in);
    endtask
    task automatic t_regs;
        apb(1'b0, RXPBC_OFS_LIMMIN, 32'h0);
        `CHK("limmin reset", {24'h0, RXPBC_LIMMIN_RST}, last_rd)
        apb(1'b1, RXPBC_OFS_LIMMAX, 32'hff);
        apb(1'b0, RXPBC_OFS_LIMMAX, 32'h0);
        `CHK("limmax width", 32'h3f, last_rd)
        apb(1'b0, 8'h20, 32'h0);
        `CHK("unmapped", 1'b1, last_err)
        $display("t_regs done");
    endtask
    task automatic t_sleep;
        for (int e = 0; e < 2; e++) begin
            cfg(e ? 8'h21 : 8'h02, 8'h4a, 8'h02, 1'b0, 60);
            wait_sig(pll_enable_out, 1'b1, 9000);
            `CHK("sleep span", 1'b1, n >= 2048 * (e ? 4 : 1) && n <= 2048 * (e ? 4 : 1) + 8)
        end
        $display("t_sleep done");
    endtask
    task automatic t_fail;
        for (int s = 0; s < 2; s++) begin
            cfg(8'h01, 8'h4a, 8'h02, !s, 20);
            wait_sig(pll_enable_out, 1'b1, 1100);
            wait_sig(rx_activity_indicator_out, 1'b0, 200);
            `CHK("abort span", 1'b1, s ? (n >= 84 && n <= 104) : n < 60)
            `CHK("no receive", 1'b0, receiving_out)
            wait_sig(pll_enable_out, 1'b1, 1100);
            `CHK("wake again", 1'b1, pll_enable_out)
        end
        $display("t_fail done");
    endtask
    task automatic t_bits;
        for (int k = 0; k < 4; k++) begin
            cfg(8'h00, {k[1:0], 6'h0a}, 8'h02, 1'b1, 60);
            wait_sig(pll_enable_out, 1'b1, 100);
            wait_sig(receiving_out, 1'b1, 1500);
            `CHK("check count", 1'b1, n >= 360 * k && n <= 360 * k + 40)
            `CHK("supply on", 1'b1, supply_output_enable_out && clock_output_enable_out)
            `CHK("irq", 1'b1, irq_out)
        end
        $display("t_bits done");
    endtask
    task automatic t_cont;
        apb(1'b1, RXPBC_OFS_STATUS, 32'h30);
        cfg(8'h02, 8'h4a, 8'h07, 1'b0, 60);
        wait_sig(pll_enable_out, 1'b1, 100);
        `CHK("no sleep", 1'b1, n < 20)
        wait_sig(rx_activity_indicator_out, 1'b0, 300);
        `CHK("stays on", 300, n)
        tx_on <= 1'b1;
        wait_sig(receiving_out, 1'b1, 1000);
        `CHK("cont receive", 1'b1, receiving_out)
        `CHK("irq masked", 1'b0, irq_out)
        $display("t_cont done");
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        #400000;
        err_count++;
        complete_run();
    end
    initial begin
        {psel_in, penable_in, pwrite_in, pll_lock_in, tx_on} = 5'h00;
        paddr_in = 8'h00;
        pwdata_in = 32'h0;
        srst_in = 1'b1;
        half = 60;
        lock_cnt = 0;
        repeat (4) @(posedge ref_clk_in);
        srst_in <= 1'b0;
        t_regs();
        apb(1'b1, RXPBC_OFS_CLKDIV, 32'h0003_0000);
        apb(1'b1, RXPBC_OFS_LIMMAX, 32'h14);
        t_sleep();
        t_fail();
        t_bits();
        t_cont();
        complete_run();
    end
endmodule
